// ---- inc/ocsfd_map.svh ----
/*
 * Offsets, field positions, reset values and timing counts for the
 * output clock sync and fine delay block.
 * Assumes inclusion by bare name from package or modules.
 */
`ifndef OCSFD_MAP_SVH
`define OCSFD_MAP_SVH

// write-only configuration registers, 4-bit serial address space
`define OCSFD_ADDR_I_OFFSET     4'h2
`define OCSFD_ADDR_Q_OFFSET     4'ha
`define OCSFD_ADDR_COARSE       4'he
`define OCSFD_ADDR_FINE         4'hf

// reset values as whole 16-bit words
`define OCSFD_RST_OFFSET        16'h007f
`define OCSFD_RST_COARSE        16'h07ff
`define OCSFD_RST_FINE          16'h007f

// field positions
`define OCSFD_FINE_MSB          15
`define OCSFD_FINE_LSB          7
`define OCSFD_DIR_BIT           14
`define OCSFD_COARSE_MSB        13
`define OCSFD_COARSE_LSB        11
`define OCSFD_OFS_MSB           15
`define OCSFD_OFS_LSB           8
`define OCSFD_OFS_SIGN_BIT      7

// datapath: raw results carry 4 fraction bits (1/16 code)
`define OCSFD_MIDSCALE          14'sh0800
`define OCSFD_FULL_RANGE        14'sh1000
`define OCSFD_NEG_ZERO_STEP     14'sh0002

// sample-clock falling edges from alignment to first toggle
`define OCSFD_TSD_EDGES         4'h4

`endif

// ---- inc/ocsfd_pkg.sv ----
/*
 * Types of the output clock sync and fine delay block.
 * Assumes ocsfd_map.svh on the include path.
 */
package ocsfd_pkg;
   `include "ocsfd_map.svh"

   // output clock sequencer, one-hot
   typedef enum logic [3:0] {
      OCSFD_RUN   = 4'h1,
      OCSFD_HOLD  = 4'h2,
      OCSFD_ALIGN = 4'h4,
      OCSFD_DELAY = 4'h8
   } ocsfd_state_t;

   typedef logic [15:0] ocsfd_word_t;
   typedef logic [8:0]  ocsfd_fine_t;
   typedef logic [2:0]  ocsfd_coarse_t;
   typedef logic [7:0]  ocsfd_code_t;
endpackage

// ---- src/ocsfd_sync.sv ----
/*
 * Two-flop level synchroniser for a small bundle of pins.
 * Assumes each bit is an independent level from outside clk_i.
 */
`timescale 1ns/10ps
`default_nettype none

module ocsfd_sync #(
   parameter int WIDTH = 4
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   // pins in, synchronised levels out
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // first stage feeds only the second stage
   always_comb begin
      meta_d = async_i;
      sync_d = meta_q;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_o = sync_q;

endmodule
`default_nettype wire

// ---- src/ocsfd_top.sv ----
/*
 * Output data clock reset/alignment, I/Q-steered fine and coarse delay
 * registers, offset correction, offset-binary coding with clipping and
 * the out-of-range flag of a dual converter.
 * Assumes the serial deframer and converter core run on clk_i; the
 * sample clock and the pins arrive from outside and are synchronised.
 */
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
module ocsfd_top
   import ocsfd_pkg::*;
(
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   // configuration writes from the serial deframer
   input  wire logic              cfg_we_i,
   input  wire logic [3:0]        cfg_addr_i,
   input  wire ocsfd_pkg::ocsfd_word_t cfg_wdata_i,
   // pins from the far side
   input  wire logic              smp_clk_i,
   input  wire logic              output_clock_reset_i,
   input  wire logic              ddr_mode_i,
   input  wire logic              output_edge_select_i,
   // converter core
   input  wire logic signed [11:0] raw_i_i,
   input  wire logic signed [11:0] raw_q_i,
   input  wire logic              raw_valid_i,
   input  wire logic              cal_busy_i,
   // sample clock delay controls
   output ocsfd_pkg::ocsfd_fine_t   i_fine_delay_o,
   output ocsfd_pkg::ocsfd_fine_t   q_fine_delay_o,
   output ocsfd_pkg::ocsfd_coarse_t i_coarse_delay_o,
   output ocsfd_pkg::ocsfd_coarse_t q_coarse_delay_o,
   // output side
   output logic                   output_data_clock_o,
   output ocsfd_pkg::ocsfd_code_t  data_i_o,
   output ocsfd_pkg::ocsfd_code_t  data_q_o,
   output logic                   out_of_range_p_o,
   output logic                   out_of_range_n_o,
   output logic                   calibration_running_o
);
   import ocsfd_pkg::*;

   /////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [3:0] pin_s;
   logic       smp_s;
   logic       ocr_s;
   logic       ddr_s;
   logic       edge_s;

   // reset pin may move at any time, so it is only read synchronised
   ocsfd_sync #(
      .WIDTH (4)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .async_i ({smp_clk_i, output_clock_reset_i,
                 ddr_mode_i, output_edge_select_i}),
      .sync_o  (pin_s)
   );

   assign smp_s  = pin_s[3];
   assign ocr_s  = pin_s[2];
   assign ddr_s  = pin_s[1];
   assign edge_s = pin_s[0];

   /////////////////////////////////////////////////////////////////////
   // write-only configuration registers
   ocsfd_fine_t   fine_q,  fine_d;
   logic          dir_q,   dir_d;
   ocsfd_coarse_t coarse_q, coarse_d;
   logic [7:0]    ofs_mag_q [2];
   logic [7:0]    ofs_mag_d [2];
   logic          ofs_neg_q [2];
   logic          ofs_neg_d [2];

   // only named fields are kept; filler bits are never stored
   always_comb begin
      fine_d    = fine_q;
      dir_d     = dir_q;
      coarse_d  = coarse_q;
      ofs_mag_d = ofs_mag_q;
      ofs_neg_d = ofs_neg_q;
      if (cfg_we_i) begin
         case (cfg_addr_i)
            `OCSFD_ADDR_FINE: begin
               fine_d = cfg_wdata_i[`OCSFD_FINE_MSB:`OCSFD_FINE_LSB];
            end
            `OCSFD_ADDR_COARSE: begin
               dir_d    = cfg_wdata_i[`OCSFD_DIR_BIT];
               coarse_d = cfg_wdata_i[`OCSFD_COARSE_MSB:`OCSFD_COARSE_LSB];
            end
            `OCSFD_ADDR_I_OFFSET: begin
               ofs_mag_d[0] = cfg_wdata_i[`OCSFD_OFS_MSB:`OCSFD_OFS_LSB];
               ofs_neg_d[0] = cfg_wdata_i[`OCSFD_OFS_SIGN_BIT];
            end
            `OCSFD_ADDR_Q_OFFSET: begin
               ofs_mag_d[1] = cfg_wdata_i[`OCSFD_OFS_MSB:`OCSFD_OFS_LSB];
               ofs_neg_d[1] = cfg_wdata_i[`OCSFD_OFS_SIGN_BIT];
            end
            default: begin
               fine_d = fine_q;  // other addresses belong elsewhere
            end
         endcase
      end
   end

   localparam ocsfd_word_t RST_FINE   = `OCSFD_RST_FINE;
   localparam ocsfd_word_t RST_COARSE = `OCSFD_RST_COARSE;
   localparam ocsfd_word_t RST_OFS    = `OCSFD_RST_OFFSET;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fine_q    <= RST_FINE[`OCSFD_FINE_MSB:`OCSFD_FINE_LSB];
         dir_q     <= RST_COARSE[`OCSFD_DIR_BIT];
         coarse_q  <= RST_COARSE[`OCSFD_COARSE_MSB:`OCSFD_COARSE_LSB];
         for (int c = 0; c < 2; c++) begin
            ofs_mag_q[c] <= RST_OFS[`OCSFD_OFS_MSB:`OCSFD_OFS_LSB];
            ofs_neg_q[c] <= RST_OFS[`OCSFD_OFS_SIGN_BIT];
         end
      end else begin
         fine_q    <= fine_d;
         dir_q     <= dir_d;
         coarse_q  <= coarse_d;
         ofs_mag_q <= ofs_mag_d;
         ofs_neg_q <= ofs_neg_d;
      end
   end

   /////////////////////////////////////////////////////////////////////
   // delay steering and calibration indicator
   ocsfd_fine_t   i_fine_q, i_fine_d, q_fine_q, q_fine_d;
   ocsfd_coarse_t i_crs_q, i_crs_d, q_crs_q, q_crs_d;
   logic          cal_q, cal_d;

   // unselected channel keeps a fixed clock; zero field means no delay
   always_comb begin
      i_fine_d = dir_q ? '0 : fine_q;
      q_fine_d = dir_q ? fine_q : '0;
      i_crs_d  = dir_q ? '0 : coarse_q;
      q_crs_d  = dir_q ? coarse_q : '0;
      cal_d    = cal_busy_i;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         i_fine_q <= '0;
         q_fine_q <= '0;
         i_crs_q  <= '0;
         q_crs_q  <= '0;
         cal_q    <= 1'b0;
      end else begin
         i_fine_q <= i_fine_d;
         q_fine_q <= q_fine_d;
         i_crs_q  <= i_crs_d;
         q_crs_q  <= q_crs_d;
         cal_q    <= cal_d;
      end
   end

   assign i_fine_delay_o        = i_fine_q;
   assign q_fine_delay_o        = q_fine_q;
   assign i_coarse_delay_o      = i_crs_q;
   assign q_coarse_delay_o      = q_crs_q;
   assign calibration_running_o = cal_q;

   /////////////////////////////////////////////////////////////////////
   // output data clock sequencer
   ocsfd_state_t st_q, st_d;
   logic         smp_q;
   logic         output_data_clock_q, output_data_clock_d;
   logic [3:0]   lat_q, lat_d;
   logic         smp_fall;
   logic         idle_lvl;

   assign smp_fall = smp_q & ~smp_s;

   // sdr with rising-edge data holds low, falling-edge holds high
   assign idle_lvl = ddr_s ? 1'b0 : ~edge_s;

   // a reset raised mid-cycle may clip output_data_clock into a narrow pulse;
   // calibration is not guarded here, the far side keeps off it
   always_comb begin
      st_d   = st_q;
      output_data_clock_d = output_data_clock_q;
      lat_d  = lat_q;
      if (ocr_s) begin
         st_d   = OCSFD_HOLD;
         output_data_clock_d = idle_lvl;
      end else begin
         case (st_q)
            OCSFD_RUN: begin
               if (smp_fall) output_data_clock_d = ~output_data_clock_q;
            end
            OCSFD_HOLD: begin
               output_data_clock_d = idle_lvl;
               st_d   = OCSFD_ALIGN;  // release seen, sample rise
            end
            OCSFD_ALIGN: begin
               output_data_clock_d = idle_lvl;
               if (smp_fall) begin
                  st_d  = OCSFD_DELAY;  // phase reference
                  lat_d = '0;
               end
            end
            OCSFD_DELAY: begin
               output_data_clock_d = idle_lvl;
               if (smp_fall) begin
                  lat_d = lat_q + 4'h1;
                  if (lat_q == `OCSFD_TSD_EDGES - 4'h1) begin
                     st_d   = OCSFD_RUN;
                     output_data_clock_d = ~idle_lvl;
                  end
               end
            end
            default: begin
               st_d = OCSFD_HOLD;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q   <= OCSFD_RUN;
         smp_q  <= 1'b0;
         output_data_clock_q <= 1'b0;
         lat_q  <= '0;
      end else begin
         st_q   <= st_d;
         smp_q  <= smp_s;
         output_data_clock_q <= output_data_clock_d;
         lat_q  <= lat_d;
      end
   end

   assign output_data_clock_o = output_data_clock_q;

   /////////////////////////////////////////////////////////////////////
   // offset correction, coding and clipping per channel
   logic signed [11:0] raw    [2];
   ocsfd_code_t        code_q [2];
   ocsfd_code_t        code_d [2];
   logic               oor_c  [2];
   logic               oor_q, oor_d;
   logic               oor_n_q, oor_n_d;

   assign raw[0] = raw_i_i;
   assign raw[1] = raw_q_i;

   for (genvar c = 0; c < 2; c++) begin : g_chan
      logic signed [13:0] adj;
      logic signed [13:0] sum;
      // zero input lands on 80h.0, the 7Fh/80h boundary
      always_comb begin
         adj = ofs_neg_q[c]
               ? -($signed({6'h00, ofs_mag_q[c]}) + `OCSFD_NEG_ZERO_STEP)
               : $signed({6'h00, ofs_mag_q[c]});
         sum = $signed({{2{raw[c][11]}}, raw[c]}) + adj + `OCSFD_MIDSCALE;
         oor_c[c]  = 1'b0;
         code_d[c] = code_q[c];
         if (raw_valid_i) begin
            if (sum < 14'sh0000) begin
               code_d[c] = 8'h00;  // clip, never wrap
               oor_c[c]  = 1'b1;
            end else if (sum >= `OCSFD_FULL_RANGE) begin
               code_d[c] = 8'hff;
               oor_c[c]  = 1'b1;
            end else begin
               code_d[c] = sum[11:4];
            end
         end
      end
   end

   // flag follows the latest sample pair
   always_comb begin
      oor_d = raw_valid_i ? (oor_c[0] | oor_c[1]) : oor_q;
      oor_n_d = ~oor_d;  // own flop, both legs switch on one edge
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         code_q[0] <= 8'h80;
         code_q[1] <= 8'h80;
         oor_q     <= 1'b0;
         oor_n_q   <= 1'b1;
      end else begin
         code_q <= code_d;
         oor_q  <= oor_d;
         oor_n_q <= oor_n_d;
      end
   end

   assign data_i_o         = code_q[0];
   assign data_q_o         = code_q[1];
   assign out_of_range_p_o = oor_q;
   assign out_of_range_n_o = oor_n_q;

endmodule
`default_nettype wire

// ---- tb/ocsfd_top_properties.sv ----
/* Concurrent checks on the ports of ocsfd_top, bound below.
   Assumes one clock domain and an 80 ns sample clock from the partner. */
`timescale 1ns/10ps
`default_nettype none
module ocsfd_top_checker
   import ocsfd_pkg::*;
(
   // clock, reset and inputs
   input wire logic                   clk_i,
   input wire logic                   rst_n_i,
   input wire logic                   cfg_we_i,
   input wire logic [3:0]             cfg_addr_i,
   input wire ocsfd_pkg::ocsfd_word_t cfg_wdata_i,
   input wire logic                   smp_clk_i,
   input wire logic                   output_clock_reset_i,
   input wire logic                   ddr_mode_i,
   input wire logic                   output_edge_select_i,
   input wire logic                   raw_valid_i,
   input wire logic                   cal_busy_i,
   // outputs watched
   input wire ocsfd_pkg::ocsfd_fine_t   i_fine_delay_o,
   input wire ocsfd_pkg::ocsfd_fine_t   q_fine_delay_o,
   input wire ocsfd_pkg::ocsfd_coarse_t i_coarse_delay_o,
   input wire ocsfd_pkg::ocsfd_coarse_t q_coarse_delay_o,
   input wire logic                   output_data_clock_o,
   input wire ocsfd_pkg::ocsfd_code_t  data_i_o,
   input wire ocsfd_pkg::ocsfd_code_t  data_q_o,
   input wire logic                   out_of_range_p_o,
   input wire logic                   out_of_range_n_o,
   input wire logic                   calibration_running_o
);
   logic          dir_d, dir_q, armed_d, armed_q, smp_q, output_data_clock_q;
   ocsfd_fine_t   fine_d, fine_q;
   ocsfd_coarse_t coarse_d, coarse_q;
   logic [3:0]    falls_d, falls_q;

   ////////////////////////////////////////////////////////////////////////
   // mirror of steering fields; raw sample falls counted after release
   always_comb begin
      dir_d = dir_q;
      fine_d = fine_q;
      coarse_d = coarse_q;
      armed_d = armed_q;
      falls_d = falls_q;
      if (cfg_we_i && cfg_addr_i == 4'hf) begin
         fine_d = cfg_wdata_i[15:7];
      end
      if (cfg_we_i && cfg_addr_i == 4'he) begin
         dir_d = cfg_wdata_i[14];
         coarse_d = cfg_wdata_i[13:11];
      end
      if (output_clock_reset_i) begin
         armed_d = 1'b1;
         falls_d = 4'h0;
      end else if (armed_q && output_data_clock_o != output_data_clock_q) begin
         armed_d = 1'b0;
      end else if (armed_q && smp_q && !smp_clk_i && falls_q != 4'hf) begin
         falls_d = falls_q + 4'h1;
      end
   end

   // helper registers only
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {dir_q, fine_q, coarse_q, armed_q, falls_q, smp_q, output_data_clock_q} <= '0;
      end else begin
         {dir_q, fine_q, coarse_q} <= {dir_d, fine_d, coarse_d};
         {armed_q, falls_q} <= {armed_d, falls_d};
         {smp_q, output_data_clock_q} <= {smp_clk_i, output_data_clock_o};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // a steering write with no other steering write right after it
   sequence wr_quiet(logic [3:0] a);
      cfg_we_i && cfg_addr_i == a ##1 !(cfg_we_i && cfg_addr_i[3:1] == 3'h7);
   endsequence

   chk_fine_steer: assert property (
      wr_quiet(4'hf) |-> ##1 (i_fine_delay_o == (dir_q ? 9'h000 : fine_q)
         && q_fine_delay_o == (dir_q ? fine_q : 9'h000)))
      else $error("fine delay not on the selected channel");
   chk_coarse_steer: assert property (
      wr_quiet(4'he) |-> ##1 (i_coarse_delay_o == (dir_q ? 3'h0 : coarse_q)
         && q_coarse_delay_o == (dir_q ? coarse_q : 3'h0)))
      else $error("coarse delay not on the selected channel");
   chk_hold_idle: assert property (
      (output_clock_reset_i && $stable(ddr_mode_i)
         && $stable(output_edge_select_i))[*4]
      |-> output_data_clock_o == (ddr_mode_i ? 1'b0 : !output_edge_select_i))
      else $error("data clock not at idle level in reset");
   chk_resume_edge: assert property (
      armed_q && !output_clock_reset_i && output_data_clock_o != output_data_clock_q
      |-> falls_q == 4'h5
         && output_data_clock_o == (ddr_mode_i || output_edge_select_i))
      else $error("data clock resumed at the wrong sample fall");
   chk_oor_legs: assert property (
      out_of_range_n_o == !out_of_range_p_o)
      else $error("range flag legs not complementary");
   chk_oor_clip: assert property (
      out_of_range_p_o |-> data_i_o inside {8'h00, 8'hff}
         || data_q_o inside {8'h00, 8'hff})
      else $error("range flag without a clipped code");
   chk_data_stands: assert property (
      !raw_valid_i |=> $stable({data_i_o, data_q_o, out_of_range_p_o}))
      else $error("codes changed without a new sample");
   chk_cal_follow: assert property (
      $past(rst_n_i) |-> calibration_running_o == $past(cal_busy_i))
      else $error("calibration indicator does not follow busy");
endmodule

bind ocsfd_top ocsfd_top_checker chk_u (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_we_i(cfg_we_i),
   .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
   .smp_clk_i(smp_clk_i), .output_clock_reset_i(output_clock_reset_i),
   .ddr_mode_i(ddr_mode_i), .output_edge_select_i(output_edge_select_i),
   .raw_valid_i(raw_valid_i), .cal_busy_i(cal_busy_i),
   .i_fine_delay_o(i_fine_delay_o), .q_fine_delay_o(q_fine_delay_o),
   .i_coarse_delay_o(i_coarse_delay_o), .q_coarse_delay_o(q_coarse_delay_o),
   .output_data_clock_o(output_data_clock_o), .data_i_o(data_i_o),
   .data_q_o(data_q_o), .out_of_range_p_o(out_of_range_p_o),
   .out_of_range_n_o(out_of_range_n_o),
   .calibration_running_o(calibration_running_o)
);
`default_nettype wire

// ---- tb/ocsfd_capture.sv ----
/* Capture-side partner: free sample clock and the data clock reset pulse.
   Assumes the bench requests pulses and passes the calibration flag. */
`timescale 1ns/10ps
`default_nettype none
module ocsfd_capture (
   // request and device indicator
   input  wire logic go_i,
   input  wire logic cal_running_i,
   // pins toward the device
   output logic      smp_clk_o,
   output logic      output_clock_reset_o
);
   // sample clock runs free at 80 ns, edges 2 ns ahead of a system clock rise
   initial begin
      smp_clk_o = 1'b0;
      output_clock_reset_o = 1'b0;
      #3;
      forever #40 smp_clk_o = ~smp_clk_o;
   end

   // never pulse during calibration; release just after a sample rise
   always @(posedge go_i) begin
      if (!cal_running_i) begin
         output_clock_reset_o = 1'b1;
         repeat (3) @(posedge smp_clk_o);
         #1 output_clock_reset_o = 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- tb/ocsfd_top_bench.sv ----
/* Self-checking bench for ocsfd_top with the capture partner.
   Assumes the checker attaches itself through its own bind. */
`timescale 1ns/10ps
`default_nettype none
`define CHECK(act, exp) begin n_compared++; if ((act) !== (exp)) begin \
   err_count++; $display("ERROR %0t: got %h expected %h", $time, act, exp); \
   end end
module ocsfd_top_bench;
   import ocsfd_pkg::*;
   typedef struct packed {
      ocsfd_word_t oi, oq;
      logic [11:0] ri, rq;
      ocsfd_code_t ei, eq;
      logic        eo;
   } ocsfd_row_t;
   // offset words, raw pair, expected codes and range flag
   localparam ocsfd_row_t ROWS [6] = '{
      '{16'h007f, 16'h007f, 12'h000, 12'hfff, 8'h80, 8'h7f, 1'b0},
      '{16'h007f, 16'h007f, 12'h800, 12'h7ff, 8'h00, 8'hff, 1'b0},
      '{16'hff7f, 16'h00ff, 12'h7ff, 12'h000, 8'hff, 8'h7f, 1'b1},
      '{16'hff7f, 16'h00ff, 12'h800, 12'h001, 8'h0f, 8'h7f, 1'b0},
      '{16'h007f, 16'h007f, 12'h000, 12'h001, 8'h80, 8'h80, 1'b0},
      '{16'h007f, 16'hffff, 12'h000, 12'h800, 8'h80, 8'h00, 1'b1}};
   logic        clk_i = 1'b0, rst_n_i = 1'b0, cfg_we_i = 1'b0, go = 1'b0;
   logic [3:0]  cfg_addr_i = 4'h0;
   ocsfd_word_t cfg_wdata_i = 16'h0000;
   logic        ddr_mode_i = 1'b0, output_edge_select_i = 1'b0, idle;
   logic signed [11:0] raw_i_i = 12'sh000, raw_q_i = 12'sh000;
   logic        raw_valid_i = 1'b0, cal_busy_i = 1'b0;
   logic        smp_clk_i, output_clock_reset_i, output_data_clock_o;
   logic        out_of_range_p_o, out_of_range_n_o, calibration_running_o;
   ocsfd_fine_t i_fine_delay_o, q_fine_delay_o;
   ocsfd_coarse_t i_coarse_delay_o, q_coarse_delay_o;
   ocsfd_code_t data_i_o, data_q_o;
   ocsfd_row_t  r;
   logic [17:0] got;
   int          err_count = 0, n_compared = 0;

   ocsfd_capture partner_u (.go_i(go), .cal_running_i(calibration_running_o),
      .smp_clk_o(smp_clk_i), .output_clock_reset_o(output_clock_reset_i));
   ocsfd_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_we_i(cfg_we_i),
      .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
      .smp_clk_i(smp_clk_i), .output_clock_reset_i(output_clock_reset_i),
      .ddr_mode_i(ddr_mode_i), .output_edge_select_i(output_edge_select_i),
      .raw_i_i(raw_i_i), .raw_q_i(raw_q_i), .raw_valid_i(raw_valid_i),
      .cal_busy_i(cal_busy_i), .i_fine_delay_o(i_fine_delay_o),
      .q_fine_delay_o(q_fine_delay_o), .i_coarse_delay_o(i_coarse_delay_o),
      .q_coarse_delay_o(q_coarse_delay_o), .data_i_o(data_i_o),
      .output_data_clock_o(output_data_clock_o), .data_q_o(data_q_o),
      .out_of_range_p_o(out_of_range_p_o), .out_of_range_n_o(out_of_range_n_o),
      .calibration_running_o(calibration_running_o));

   ////////////////////////////////////////////////////////////////////////
   always #5 clk_i = ~clk_i;

   // one-cycle write strobe, launched on the falling edge
   task automatic wr(input logic [3:0] a, input ocsfd_word_t d);
      @(negedge clk_i);
      {cfg_we_i, cfg_addr_i, cfg_wdata_i} = {1'b1, a, d};
      @(negedge clk_i);
      cfg_we_i = 1'b0;
   endtask

   // one sample pair; codes are registered by the next rising edge
   task automatic smp(input logic [11:0] ri, input logic [11:0] rq);
      @(negedge clk_i);
      {raw_valid_i, raw_i_i, raw_q_i} = {1'b1, ri, rq};
      @(negedge clk_i);
      raw_valid_i = 1'b0;
   endtask

   task automatic pulse();
      @(negedge clk_i) go = 1'b1;
      @(negedge clk_i) go = 1'b0;
   endtask

   // bounded wait; running out ends the run as a failure
   task automatic wait_output_data_clock(input logic lvl);
      int k;
      for (k = 0; k < 200; k++) begin
         if (output_data_clock_o === lvl) break;
         @(negedge clk_i);
      end
      if (k == 200) begin
         err_count++;
         complete_run();
      end
   endtask

   task automatic complete_run();
      if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(negedge clk_i);
      `CHECK({data_i_o, out_of_range_n_o, i_fine_delay_o}, 18'h20200)
      rst_n_i = 1'b1;
      foreach (ROWS[n]) begin
         r = ROWS[n];
         wr(4'h2, r.oi);
         wr(4'ha, r.oq);
         smp(r.ri, r.rq);
         got = {data_i_o, data_q_o, out_of_range_p_o, out_of_range_n_o};
         `CHECK(got, {r.ei, r.eq, r.eo, !r.eo})
      end
      // fine field, unmapped write ignored, then direction flip
      wr(4'hf, 16'hff7f);
      wr(4'h3, 16'h0000);
      `CHECK({i_fine_delay_o, q_fine_delay_o}, {9'h1fe, 9'h000})
      wr(4'he, 16'h6fff);
      @(negedge clk_i);
      `CHECK({q_fine_delay_o, i_fine_delay_o}, {9'h1fe, 9'h000})
      `CHECK({q_coarse_delay_o, i_coarse_delay_o}, {3'h5, 3'h0})
      wr(4'hf, 16'h007f);
      @(negedge clk_i);
      `CHECK({i_fine_delay_o, q_fine_delay_o}, 18'h00000)
      // data clock reset in each output mode
      for (int m = 0; m < 3; m++) begin
         ddr_mode_i = (m == 2);
         output_edge_select_i = (m == 1);
         idle = (m == 0);
         repeat (4) @(negedge clk_i);
         pulse();
         repeat (8) @(negedge clk_i);
         `CHECK(output_data_clock_o, idle)
         wait_output_data_clock(!idle);
         repeat (4) @(negedge clk_i);
         `CHECK(output_data_clock_o, !idle)
         repeat (4) @(negedge clk_i);
         `CHECK(output_data_clock_o, idle)
      end
      // partner stays quiet while calibration runs
      cal_busy_i = 1'b1;
      repeat (2) @(negedge clk_i);
      `CHECK(calibration_running_o, 1'b1)
      pulse();
      `CHECK(output_clock_reset_i, 1'b0)
      repeat (40) @(negedge clk_i);
      cal_busy_i = 1'b0;
      // second reset in mid-run returns the I code to 80h and clears the Q delays
      wr(4'hf, 16'hff7f);
      @(negedge clk_i);
      rst_n_i = 1'b0;
      #1;
      got = {data_i_o, out_of_range_n_o, q_fine_delay_o};
      `CHECK({got, q_coarse_delay_o}, 21'h101000)
      repeat (2) @(negedge clk_i);
      rst_n_i = 1'b1;
      smp(12'h000, 12'hfff);
      `CHECK({data_i_o, data_q_o}, 16'h807f)
      complete_run();
   end
endmodule
`default_nettype wire
